// [inc/sac_pkg.sv]
// Shared constants and types of the scan acquisition controller
package sac_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_AI     = 8;
    localparam int DIO_WIDTH  = 8;
    localparam int FIFO_DEPTH = 64;
    localparam int PTR_W      = 6;

    localparam logic [3:0] DIN_CHANNEL = 4'h8;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS    = 20;
    localparam int BASE_PERIOD_NS   = 100_000_000;
    localparam int BASE_CYCLES      = BASE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TRIG_HOLD_MS     = 100;
    localparam int TRIG_HOLD_CYCLES =
        (TRIG_HOLD_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // Register word addresses
    // ****************************************************************
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_CONFIG    = 8'h01;
    localparam logic [7:0] REG_CHAN_EN   = 8'h02;
    localparam logic [7:0] REG_CLK_DIV   = 8'h03;
    localparam logic [7:0] REG_KIND      = 8'h04;
    localparam logic [7:0] REG_STATUS    = 8'h05;
    localparam logic [7:0] REG_FIFO_DATA = 8'h06;
    localparam logic [7:0] REG_DIN       = 8'h07;
    localparam logic [7:0] REG_DOUT      = 8'h08;
    localparam logic [7:0] REG_DIN_LINE  = 8'h10;
    localparam logic [7:0] REG_DOUT_LINE = 8'h18;

    // Field positions
    localparam int CTRL_START  = 0;
    localparam int CTRL_STOP   = 1;
    localparam int CTRL_SINGLE = 2;
    localparam int CFG_EXT     = 0;
    localparam int CFG_CJ      = 1;

    // Reset values
    localparam logic [8:0]  CHAN_EN_RESET = 9'h000;
    localparam logic [15:0] CLK_DIV_RESET = 16'h0001;
    localparam logic [15:0] KIND_RESET    = 16'h0000;
    localparam logic [7:0]  DOUT_RESET    = 8'h00;

    // ****************************************************************
    // Sensor kinds, input status and substitute words
    // ****************************************************************
    localparam logic [1:0] KIND_VOLT = 2'h0;
    localparam logic [1:0] KIND_TC   = 2'h1;
    localparam logic [1:0] KIND_RTD  = 2'h2;
    localparam logic [1:0] KIND_OHMS = 2'h3;

    localparam logic [1:0] STAT_OK    = 2'h0;
    localparam logic [1:0] STAT_OPEN  = 2'h1;
    localparam logic [1:0] STAT_OVER  = 2'h2;
    localparam logic [1:0] STAT_UNDER = 2'h3;

    localparam logic [31:0] OPEN_SENSOR_CODE = 32'h47c34f80;
    localparam logic [31:0] OVER_RANGE_CODE  = 32'h47ad9c00;
    localparam logic [31:0] UNDER_RANGE_CODE = 32'hc7ad9c00;

    typedef logic [NUM_AI-1:0][31:0] sac_words_t;
    typedef logic [NUM_AI-1:0][1:0]  sac_stats_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_LOW,
        ST_WAIT_HIGH,
        ST_RUN,
        ST_CONV,
        ST_EMIT,
        ST_HALT
    } sac_state_t;

endpackage

// [core/sac_core.sv]
// Scan acquisition controller: trigger, scan sequencing, ring FIFO, digital I/O
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module sac_core
#(
    parameter int BASE_CYC = sac_pkg::BASE_CYCLES,
    parameter int HOLD_CYC = sac_pkg::TRIG_HOLD_CYCLES
)
(
    input  wire logic                           ref_clk,
    input  wire logic                           rstn,
    input  wire logic [7:0]                     reg_addr,
    input  wire logic [31:0]                    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [31:0]                    reg_rdata,
    input  wire logic [sac_pkg::DIO_WIDTH-1:0]  din,
    output logic      [sac_pkg::DIO_WIDTH-1:0]  dout,
    output logic                                conv_start,
    input  wire logic                           conv_done,
    input  wire sac_pkg::sac_words_t            ai_volt,
    input  wire sac_pkg::sac_words_t            ai_temp,
    input  wire sac_pkg::sac_words_t            ai_ohm,
    input  wire sac_pkg::sac_stats_t            ai_status,
    input  wire sac_pkg::sac_words_t            cj_temp,
    output logic                                overrun_event,
    output logic                                acq_active
);
    import sac_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        sac_state_t           st;
        logic                 single;
        logic                 ext_trig;
        logic                 cj_en;
        logic [8:0]           chan_en;
        logic [15:0]          clk_div;
        logic [15:0]          kind;
        logic [7:0]           dout;
        logic [22:0]          base_cnt;
        logic [15:0]          div_cnt;
        logic [22:0]          hold_cnt;
        logic [3:0]           ch_idx;
        logic                 cj_phase;
        sac_words_t           snap_val;
        sac_words_t           snap_cj;
        logic [7:0]           snap_din;
        logic [PTR_W-1:0]     wr_ptr;
        logic [PTR_W-1:0]     rd_ptr;
        logic [PTR_W:0]       count;
        logic                 overrun;
        logic [31:0]          rdata;
        logic                 conv_start;
        logic                 overrun_evt;
    } sac_core_state_t;

    sac_core_state_t s;
    sac_core_state_t next_s;

    logic [31:0] fifo_mem [FIFO_DEPTH];
    logic        push;
    logic [31:0] push_data;

    localparam logic [22:0] BASE_LAST = 23'(BASE_CYC - 1);
    localparam logic [22:0] HOLD_LAST = 23'(HOLD_CYC - 1);
    localparam logic [PTR_W:0] FIFO_FULL = (PTR_W + 1)'(FIFO_DEPTH);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [31:0] byte_to_float(input logic [7:0] v);
        logic [31:0] f;
        logic [2:0]  msb;
        logic [7:0]  frac;
        f    = 32'h00000000;
        msb  = 3'h0;
        frac = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (v[i])
            begin
                msb = 3'(i);
            end
        end
        if (v != 8'h00)
        begin
            frac = v << (3'h7 - msb);
            f    = {1'b0, 8'(8'd127 + 8'(msb)), frac[6:0], 16'h0000};
        end
        return f;
    endfunction

    function automatic logic [31:0] pick_value(
        input logic [1:0]  kind,
        input logic [1:0]  stat,
        input logic [31:0] volt,
        input logic [31:0] temp,
        input logic [31:0] ohm
    );
        logic [31:0] r;
        r = temp;
        if (kind == KIND_VOLT)
        begin
            r = volt;
        end
        else if (stat == STAT_OPEN)
        begin
            r = OPEN_SENSOR_CODE;
        end
        else if (stat == STAT_OVER)
        begin
            r = OVER_RANGE_CODE;
        end
        else if (stat == STAT_UNDER)
        begin
            r = UNDER_RANGE_CODE;
        end
        else if (kind == KIND_OHMS)
        begin
            r = ohm;
        end
        return r;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic tick;
        logic base_pulse;
        logic pop;
        logic [3:0] nxt_idx;
        tick       = 1'b0;
        base_pulse = 1'b0;
        pop        = 1'b0;
        nxt_idx    = 4'(s.ch_idx + 4'h1);
        push       = 1'b0;
        push_data  = 32'h00000000;
        next_s     = s;
        next_s.conv_start  = 1'b0;
        next_s.overrun_evt = 1'b0;

        // Sample clock divider, runs only in ST_RUN, ST_CONV and ST_EMIT, not while waiting for the trigger
        if ((s.st == ST_RUN) || (s.st == ST_CONV) || (s.st == ST_EMIT))
        begin
            if (s.base_cnt >= BASE_LAST)
            begin
                next_s.base_cnt = 23'h000000;
                base_pulse      = 1'b1;
            end
            else
            begin
                next_s.base_cnt = 23'(s.base_cnt + 23'h1);
            end
            if (base_pulse)
            begin
                if (s.div_cnt >= 16'(s.clk_div - 16'h1))
                begin
                    next_s.div_cnt = 16'h0000;
                    tick           = ~s.single;
                end
                else
                begin
                    next_s.div_cnt = 16'(s.div_cnt + 16'h1);
                end
            end
        end

        // Register reads, data one cycle later
        next_s.rdata = 32'h00000000;
        if (reg_rd)
        begin
            if (reg_addr == REG_CONFIG)
            begin
                next_s.rdata = {30'h0, s.cj_en, s.ext_trig};
            end
            else if (reg_addr == REG_CHAN_EN)
            begin
                next_s.rdata = {23'h0, s.chan_en};
            end
            else if (reg_addr == REG_CLK_DIV)
            begin
                next_s.rdata = {16'h0, s.clk_div};
            end
            else if (reg_addr == REG_KIND)
            begin
                next_s.rdata = {16'h0, s.kind};
            end
            else if (reg_addr == REG_STATUS)
            begin
                next_s.rdata = {16'h0, 1'b0, s.count, 5'h00, s.overrun,
                                (s.st == ST_WAIT_LOW) || (s.st == ST_WAIT_HIGH),
                                (s.st != ST_IDLE) && (s.st != ST_HALT)};
            end
            else if (reg_addr == REG_FIFO_DATA)
            begin
                if ((s.count != '0) && !s.overrun)
                begin
                    next_s.rdata = fifo_mem[s.rd_ptr];
                    pop          = 1'b1;
                end
            end
            else if (reg_addr == REG_DIN)
            begin
                next_s.rdata = {24'h0, din};
            end
            else if (reg_addr == REG_DOUT)
            begin
                next_s.rdata = {24'h0, s.dout};
            end
            else if ((reg_addr & 8'hf8) == REG_DIN_LINE)
            begin
                next_s.rdata = {31'h0, din[reg_addr[2:0]]};
            end
        end

        // Register writes
        if (reg_wr)
        begin
            if (reg_addr == REG_CONFIG)
            begin
                next_s.ext_trig = reg_wdata[CFG_EXT];
                next_s.cj_en    = reg_wdata[CFG_CJ];
            end
            else if (reg_addr == REG_CHAN_EN)
            begin
                next_s.chan_en = reg_wdata[8:0];
            end
            else if (reg_addr == REG_CLK_DIV)
            begin
                next_s.clk_div = (reg_wdata[15:0] == 16'h0) ? CLK_DIV_RESET
                                                            : reg_wdata[15:0];
            end
            else if (reg_addr == REG_KIND)
            begin
                next_s.kind = reg_wdata[15:0];
            end
            else if (reg_addr == REG_DOUT)
            begin
                next_s.dout = reg_wdata[7:0];
            end
            else if ((reg_addr & 8'hf8) == REG_DOUT_LINE)
            begin
                next_s.dout[reg_addr[2:0]] = reg_wdata[0];
            end
        end

        // Ring FIFO pop, then push below
        if (pop)
        begin
            next_s.rd_ptr = PTR_W'(s.rd_ptr + 1'b1);
            next_s.count  = (PTR_W + 1)'(s.count - 1'b1);
        end

        // Acquisition sequencer
        case (s.st)
            ST_IDLE, ST_HALT:
            begin
            end
            ST_WAIT_LOW:
            begin
                if (!din[0])
                begin
                    next_s.st       = ST_WAIT_HIGH;
                    next_s.hold_cnt = 23'h000000;
                end
            end
            ST_WAIT_HIGH:
            begin
                if (!din[0])
                begin
                    next_s.hold_cnt = 23'h000000;
                end
                else if (s.hold_cnt >= HOLD_LAST)
                begin
                    next_s.st         = ST_CONV;
                    next_s.conv_start = 1'b1;
                    next_s.base_cnt   = 23'h000000;
                    next_s.div_cnt    = 16'h0000;
                end
                else
                begin
                    next_s.hold_cnt = 23'(s.hold_cnt + 23'h1);
                end
            end
            ST_RUN:
            begin
                if (tick)
                begin
                    next_s.st         = ST_CONV;
                    next_s.conv_start = 1'b1;
                end
            end
            ST_CONV:
            begin
                if (conv_done)
                begin
                    for (int c = 0; c < NUM_AI; c++)
                    begin
                        next_s.snap_val[c] = pick_value(s.kind[2*c +: 2],
                                                        ai_status[c], ai_volt[c],
                                                        ai_temp[c], ai_ohm[c]);
                    end
                    next_s.snap_cj  = cj_temp;
                    next_s.snap_din = din;
                    next_s.ch_idx   = 4'h0;
                    next_s.cj_phase = 1'b0;
                    next_s.st       = ST_EMIT;
                end
            end
            ST_EMIT:
            begin
                if (s.ch_idx == DIN_CHANNEL)
                begin
                    if (s.chan_en[DIN_CHANNEL])
                    begin
                        push      = 1'b1;
                        push_data = byte_to_float(s.snap_din);
                    end
                    next_s.st = s.single ? ST_IDLE : ST_RUN;
                end
                else if (s.chan_en[s.ch_idx])
                begin
                    push = 1'b1;
                    if (s.cj_phase)
                    begin
                        push_data       = s.snap_cj[s.ch_idx[2:0]];
                        next_s.cj_phase = 1'b0;
                        next_s.ch_idx   = nxt_idx;
                    end
                    else
                    begin
                        push_data = s.snap_val[s.ch_idx[2:0]];
                        if (s.cj_en)
                        begin
                            next_s.cj_phase = 1'b1;
                        end
                        else
                        begin
                            next_s.ch_idx = nxt_idx;
                        end
                    end
                end
                else
                begin
                    next_s.ch_idx = nxt_idx;
                end
            end
            default:
            begin
                next_s.st = ST_IDLE;
            end
        endcase

        // Scan still busy when the next sample pulse arrives
        if (tick && ((s.st == ST_CONV) || (s.st == ST_EMIT)))
        begin
            next_s.st          = ST_HALT;
            next_s.overrun     = 1'b1;
            next_s.overrun_evt = 1'b1;
            push               = 1'b0;
            next_s.conv_start  = 1'b0;
        end

        // Ring write: full overwrites the oldest entry, never stalls
        if (push)
        begin
            next_s.wr_ptr = PTR_W'(s.wr_ptr + 1'b1);
            if (next_s.count == FIFO_FULL)
            begin
                next_s.rd_ptr = PTR_W'(next_s.rd_ptr + 1'b1);
            end
            else
            begin
                next_s.count = (PTR_W + 1)'(next_s.count + 1'b1);
            end
        end

        // Commands
        if (reg_wr && (reg_addr == REG_CTRL))
        begin
            if (reg_wdata[CTRL_STOP])
            begin
                next_s.st         = ST_IDLE;
                next_s.conv_start = 1'b0;
            end
            else if (reg_wdata[CTRL_START] && (s.st == ST_IDLE || s.st == ST_HALT))
            begin
                next_s.single   = 1'b0;
                next_s.overrun  = 1'b0;
                next_s.wr_ptr   = '0;
                next_s.rd_ptr   = '0;
                next_s.count    = '0;
                next_s.base_cnt = 23'h000000;
                next_s.div_cnt  = 16'h0000;
                if (s.ext_trig)
                begin
                    next_s.st = ST_WAIT_LOW;
                end
                else
                begin
                    next_s.st         = ST_CONV;
                    next_s.conv_start = 1'b1;
                end
            end
            else if (reg_wdata[CTRL_SINGLE] && (s.st == ST_IDLE))
            begin
                next_s.single     = 1'b1;
                next_s.st         = ST_CONV;
                next_s.conv_start = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s         <= '0;
            s.st      <= ST_IDLE;
            s.chan_en <= CHAN_EN_RESET;
            s.clk_div <= CLK_DIV_RESET;
            s.kind    <= KIND_RESET;
            s.dout    <= DOUT_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            fifo_mem[s.wr_ptr] <= push_data;
        end
    end

    assign reg_rdata     = s.rdata;
    assign dout          = s.dout;
    assign conv_start    = s.conv_start;
    assign overrun_event = s.overrun_evt;
    assign acq_active    = (s.st != ST_IDLE) && (s.st != ST_HALT);

endmodule // sac_core

`default_nettype wire

// [test/sac_checker.sv]
// Port assertions for the scan acquisition controller
`timescale 1ns/1ps
`default_nettype none
module sac_checker
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0]  din,
    input wire logic [7:0]  dout,
    input wire logic        conv_start,
    input wire logic        overrun_event,
    input wire logic        acq_active
);
    import sac_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_dout_reset: assert property ($rose(rstn) |-> dout == 8'h00)
        else $error("outputs not off");
    a_dout_word: assert property (reg_wr && reg_addr == REG_DOUT
        |=> dout == $past(reg_wdata[7:0])) else $error("port write");
    a_dout_line: assert property (reg_wr && reg_addr[7:3] == 5'h03
        |=> dout[$past(reg_addr[2:0])] == $past(reg_wdata[0])) else $error("line write");
    a_din_word: assert property (reg_rd && reg_addr == REG_DIN
        |=> reg_rdata[7:0] == $past(din)) else $error("port read");
    a_conv_pulse: assert property (conv_start |=> !conv_start)
        else $error("long sample request");
    a_overrun_halt: assert property (overrun_event |=> !acq_active && !overrun_event)
        else $error("overrun not halted");
    a_stop_idle: assert property (reg_wr && reg_addr == REG_CTRL && reg_wdata[1]
        |=> !acq_active) else $error("stop ignored");
    a_single_go: assert property (!acq_active && reg_wr && reg_addr == REG_CTRL
        && reg_wdata[2:0] == 3'h4 |=> conv_start && acq_active) else $error("single late");
    a_quiet_idle: assert property (!acq_active && !reg_wr |=> !conv_start)
        else $error("request while idle");
endmodule // sac_checker
bind sac_core sac_checker sac_checker_i (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .din, .dout, .conv_start, .overrun_event, .acq_active);
`default_nettype wire

// [test/sac_conv_model.sv]
// Converter stand-in answering sample requests with fixed words
`timescale 1ns/1ps
`default_nettype none
module sac_conv_model
(
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             conv_start,
    input  wire logic             slow,
    output logic                  conv_done,
    output var sac_pkg::sac_words_t ai_volt,
    output var sac_pkg::sac_words_t ai_temp,
    output var sac_pkg::sac_words_t ai_ohm,
    output var sac_pkg::sac_words_t cj_temp
);
    import sac_pkg::*;
    int cnt;
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            cnt <= 0;
        else if (conv_start)
            cnt <= slow ? 60 : 2;
        else if (cnt > 0)
            cnt <= cnt - 1;
    assign conv_done = (cnt == 1);
    always_comb
        for (int i = 0; i < NUM_AI; i++)
        begin
            ai_volt[i] = 32'h3f800000 + 32'(i);
            ai_temp[i] = 32'h42000000 + 32'(i);
            ai_ohm[i]  = 32'h40400000 + 32'(i);
            cj_temp[i] = 32'h41c80000 + 32'(i);
        end
endmodule // sac_conv_model
`default_nettype wire

// [test/tb.sv]
// Self-checking testbench of the scan acquisition controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sac_pkg::*;
    logic        ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic [7:0]  reg_addr = 8'h00, din = 8'h00, dout;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic        conv_start, conv_done, overrun_event, acq_active;
    sac_words_t  ai_volt, ai_temp, ai_ohm, cj_temp;
    sac_stats_t  ai_status = 16'h00d9;
    int          errors = 0, checks = 0, ncs = 0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) ncs <= ncs + int'(conv_start);
    sac_core #(.BASE_CYC(40), .HOLD_CYC(4)) sac_core_i (.ref_clk, .rstn, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .din, .dout, .conv_start, .conv_done,
        .ai_volt, .ai_temp, .ai_ohm, .ai_status, .cj_temp, .overrun_event, .acq_active);
    sac_conv_model sac_conv_model_i (.ref_clk, .rstn, .conv_start, .slow, .conv_done,
        .ai_volt, .ai_temp, .ai_ohm, .cj_temp);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        cyc(1);
    endtask
    task automatic stat(input logic [6:0] n);
        rd(REG_STATUS);
        chk({25'h0, d[14:8]}, {25'h0, n});
    endtask
    task automatic drain(input logic [31:0] e [$]);
        foreach (e[i])
        begin
            rd(REG_FIFO_DATA);
            chk(d, e[i]);
        end
    endtask
    task automatic single;
        wr(REG_CTRL, 32'h4);
        cyc(2);
        for (int i = 0; i < 60 && acq_active !== 1'b0; i++) @(posedge ref_clk);
    endtask
    task automatic t_dio;
        chk({24'h0, dout}, 32'h0);
        din <= 8'h3c;
        wr(REG_DOUT, 32'ha5);
        wr(REG_DOUT_LINE, 32'h0);
        wr(REG_DOUT_LINE + 8'h6, 32'h1);
        cyc(1);
        chk({24'h0, dout}, 32'he4);
        rd(REG_DOUT);
        chk(d, 32'he4);
        rd(REG_DIN);
        chk({24'h0, d[7:0]}, 32'h3c);
        rd(REG_DIN_LINE + 8'h2);
        chk({31'h0, d[0]}, 32'h1);
    endtask
    task automatic t_single;
        wr(REG_CHAN_EN, 32'h11f);
        wr(REG_KIND, 32'h394);
        single;
        stat(7'd6);
        drain('{32'h3f800000, OVER_RANGE_CODE, OPEN_SENSOR_CODE, UNDER_RANGE_CODE,
            32'h40400004, 32'h42700000});
        ai_status <= 16'h0000;
        wr(REG_CHAN_EN, 32'h2);
        single;
        drain('{32'h42000001});
        wr(REG_CONFIG, 32'h2);
        wr(REG_CHAN_EN, 32'h101);
        single;
        drain('{32'h3f800000, 32'h41c80000, 32'h42700000});
        rd(REG_FIFO_DATA);
        chk(d, 32'h0);
    endtask
    task automatic t_run;
        int n;
        wr(REG_CONFIG, 32'h0);
        wr(REG_CLK_DIV, 32'h2);
        wr(REG_CTRL, 32'h1);
        cyc(1960);
        stat(7'd50);
        cyc(1000);
        stat(7'd64);
        chk({31'h0, acq_active}, 32'h1);
        slow <= 1'b1;
        wr(REG_CLK_DIV, 32'h1);
        wr(REG_CTRL, 32'h1);
        for (int i = 0; i < 100 && overrun_event !== 1'b1; i++) @(posedge ref_clk);
        chk({31'h0, overrun_event}, 32'h1);
        stat(7'd64);
        chk({31'h0, d[2]}, 32'h1);
        rd(REG_FIFO_DATA);
        chk(d, 32'h0);
        slow <= 1'b0;
        din <= 8'h01;
        wr(REG_CONFIG, 32'h1);
        wr(REG_CTRL, 32'h1);
        stat(7'd0);
        chk({31'h0, d[1]}, 32'h1);
        n = ncs;
        cyc(10);
        din <= 8'h00;
        cyc(2);
        din <= 8'h01;
        cyc(3);
        din <= 8'h00;
        cyc(1);
        chk(32'(ncs - n), 32'h0);
        din <= 8'h01;
        cyc(8);
        din <= 8'h00;
        cyc(3);
        din <= 8'h01;
        cyc(6);
        chk(32'(ncs - n), 32'h1);
        wr(REG_CTRL, 32'h2);
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        cyc(5);
        rstn <= 1'b1;
        cyc(1);
        t_dio;
        t_single;
        t_run;
        conclude;
    end
    initial
    begin
        #400000;
        errors++;
        conclude;
    end
endmodule // tb
`default_nettype wire
